// ===== design/urf_flags.sv
// Purpose: Receiver timeout, clear-to-send and LIN break flags with requests
// Assumes: Pins synchronous to clock_i; clear strobes last one cycle
// Notes:   Flag set beats a clear in the same cycle
`timescale 1ns/1ns
module urf_flags
  import urf_pkg::*;
#(
  parameter bit HAS_RX_TIMEOUT = 1'b1,
  parameter bit HAS_FLOW_CTRL  = 1'b1,
  parameter bit HAS_LIN        = 1'b1
) (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  // Serial pins
  input  wire logic              rx_i,
  input  wire logic              clear_to_send_pin_low_active_i,
  // Configuration
  input  wire urf_ctrl_t         ctrl_i,
  input  wire urf_irq_en_t       irq_en_i,
  input  wire logic [DIV_W-1:0]  sample_div_i,
  input  wire logic [VAL_W-1:0]  rx_timeout_value_reg_i,
  input  wire logic [VAL_W-1:0]  block_wait_value_i,
  input  wire urf_clear_t        clear_i,
  // Status
  output urf_status_t            status_o,
  output logic                   irq_o
);

  // Flag registers
  logic rto_flag_reg;
  logic rto_flag_next;
  logic rto_fired_reg;
  logic cts_stat_reg;
  logic cts_flag_reg;
  logic cts_flag_next;
  logic lbd_flag_reg;
  logic lbd_flag_next;
  logic lbd_fired_reg;
  logic rx_prev_reg;
  logic cts_prev_reg;
  logic irq_reg;

  logic                 sample_tick;
  logic                 rto_reached;
  logic                 lbd_reached;
  logic [CNT_W-1:0]     rto_limit;
  logic [CNT_W-1:0]     lbd_limit;
  logic [VAL_W-1:0]     wait_value;
  urf_wait_mode_t       wait_mode;

  // Sample ticks pace both timers
  urf_tick_div #(
    .W (DIV_W)
  ) u_tick (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .div_i   (sample_div_i),
    .tick_o  (sample_tick)
  );

  // Receive line activity
  wire rx_edge = rx_i != rx_prev_reg;
  wire rx_fall = rx_prev_reg && !rx_i;
  wire [4:0] samples_per_bit = ctrl_i.oversample8 ? SAMPLES_OVS8 : SAMPLES_OVS16;

  // Smartcard waits are measured from start bit to start bit
  assign wait_mode = ctrl_i.smartcard_mode ? WAIT_SMARTCARD : WAIT_IDLE;
  assign wait_value = (wait_mode == WAIT_SMARTCARD && ctrl_i.block_wait_sel) ?
                      block_wait_value_i : rx_timeout_value_reg_i;
  wire rto_restart = (wait_mode == WAIT_SMARTCARD) ? rx_fall : rx_edge;

  // Limit sits two samples past the programmed gap
  assign rto_limit = CNT_W'(wait_value) * CNT_W'(samples_per_bit)
                   + TIMEOUT_TOL_SAMPLES;

  // Counter runs regardless of the receiver enable
  urf_run_timer #(
    .W (CNT_W)
  ) u_rto_timer (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .tick_i    (sample_tick),
    .restart_i (rto_restart),
    .limit_i   (rto_limit),
    .reached_o (rto_reached)
  );

  // Break is a low run of ten or eleven bit times
  wire [3:0] lbd_bits = ctrl_i.lin_break_long ? LIN_BREAK_BITS_LONG
                                              : LIN_BREAK_BITS_SHORT;
  assign lbd_limit = CNT_W'(lbd_bits) * CNT_W'(samples_per_bit);

  urf_run_timer #(
    .W (CNT_W)
  ) u_lbd_timer (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .tick_i    (sample_tick),
    .restart_i (rx_i),
    .limit_i   (lbd_limit),
    .reached_o (lbd_reached)
  );

  // Write-one clears; a zero bit or an idle strobe leaves the flag alone
  wire clr_rto = clear_i.wr && clear_i.rx_timeout_clear_bit;
  wire clr_cts = clear_i.wr && clear_i.clear_to_send_change_clear_bit;
  wire clr_lbd = clear_i.wr && clear_i.lin_break_clear_bit;

  // One event per idle period so a clear is not undone while still idle
  wire set_rto = HAS_RX_TIMEOUT && rto_reached && !rto_fired_reg
              && ctrl_i.rx_enable_bit && ctrl_i.rx_timeout_en;
  wire cts_toggle = clear_to_send_pin_low_active_i != cts_prev_reg;
  wire set_cts = HAS_FLOW_CTRL && ctrl_i.clear_to_send_detect_enable
              && cts_toggle;
  wire set_lbd = HAS_LIN && ctrl_i.lin_mode_en && lbd_reached
              && !lbd_fired_reg;

  assign rto_flag_next = set_rto || (rto_flag_reg && !clr_rto);
  assign cts_flag_next = set_cts || (cts_flag_reg && !clr_cts);
  assign lbd_flag_next = set_lbd || (lbd_flag_reg && !clr_lbd);

  wire irq_next = (rto_flag_reg && irq_en_i.rx_timeout_irq_enable)
               || (cts_flag_reg && irq_en_i.clear_to_send_change_irq_enable)
               || (lbd_flag_reg && irq_en_i.lin_break_irq_enable);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rto_flag_reg  <= FLAG_RST;
      cts_flag_reg  <= FLAG_RST;
      lbd_flag_reg  <= FLAG_RST;
      rto_fired_reg <= FLAG_RST;
      lbd_fired_reg <= FLAG_RST;
      cts_stat_reg  <= STATUS_RST;
      rx_prev_reg   <= 1'b1;
      cts_prev_reg  <= 1'b1;
      irq_reg       <= 1'b0;
    end else begin
      rto_flag_reg  <= rto_flag_next;
      cts_flag_reg  <= cts_flag_next;
      lbd_flag_reg  <= lbd_flag_next;
      rto_fired_reg <= !rto_restart && (rto_fired_reg || set_rto);
      lbd_fired_reg <= !rx_i && (lbd_fired_reg || set_lbd);
      cts_stat_reg  <= HAS_FLOW_CTRL && !clear_to_send_pin_low_active_i;
      rx_prev_reg   <= rx_i;
      cts_prev_reg  <= clear_to_send_pin_low_active_i;
      irq_reg       <= irq_next;
    end
  end

  // Disabled features stay zero because their set terms are tied off
  assign status_o.rx_idle_timeout_flag      = rto_flag_reg;
  assign status_o.clear_to_send_status      = cts_stat_reg;
  assign status_o.clear_to_send_change_flag = cts_flag_reg;
  assign status_o.lin_break_flag            = lbd_flag_reg;
  assign irq_o                              = irq_reg;

  // Checks
  AST_RTO_SET: assert property (@(posedge clock_i) disable iff (srst_i)
    (HAS_RX_TIMEOUT && rto_reached && !rto_fired_reg && ctrl_i.rx_enable_bit
     && ctrl_i.rx_timeout_en) |=> rto_flag_reg)
    else $error("timeout flag not set after limit reached");

  AST_RTO_CLR: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(rto_flag_reg) |-> $past(clr_rto))
    else $error("timeout flag dropped without clear");

  AST_IRQ: assert property (@(posedge clock_i) disable iff (srst_i)
    (rto_flag_reg && irq_en_i.rx_timeout_irq_enable) |=> irq_o)
    else $error("timeout request missing");

  AST_RTO_GAP: assert property (@(posedge clock_i) disable iff (srst_i)
    rto_restart |=> !rto_reached)
    else $error("timeout reached right after activity");

  AST_RTO_RX_ON: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(rto_flag_reg) |-> $past(ctrl_i.rx_enable_bit) && $past(rto_reached))
    else $error("timeout flag set with receiver off");

  AST_CTS_LIVE: assert property (@(posedge clock_i) disable iff (srst_i)
    ##1 status_o.clear_to_send_status ==
        (HAS_FLOW_CTRL && !$past(clear_to_send_pin_low_active_i)))
    else $error("clear-to-send status not inverse of pin");

  AST_CTS_SET: assert property (@(posedge clock_i) disable iff (srst_i)
    (HAS_FLOW_CTRL && ctrl_i.clear_to_send_detect_enable
     && $changed(clear_to_send_pin_low_active_i)) |=> cts_flag_reg)
    else $error("toggle did not set change flag");

  AST_CTS_HOLD: assert property (@(posedge clock_i) disable iff (srst_i)
    (cts_flag_reg && !(clear_i.wr && clear_i.clear_to_send_change_clear_bit))
    |=> cts_flag_reg)
    else $error("change flag lost without clear");

  AST_CTS_IRQ: assert property (@(posedge clock_i) disable iff (srst_i)
    (!cts_flag_reg && !rto_flag_reg && !lbd_flag_reg) |=> !irq_o)
    else $error("request without any flag");

  AST_LBD_SET: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(lbd_flag_reg) |-> $past(lbd_reached) && !$past(rx_i, 2))
    else $error("break flag without low run");

  AST_LBD_CLR: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(lbd_flag_reg) |-> $past(clr_lbd))
    else $error("break flag dropped without clear");

  AST_LBD_IRQ: assert property (@(posedge clock_i) disable iff (srst_i)
    (lbd_flag_reg && irq_en_i.lin_break_irq_enable) |=> irq_o)
    else $error("break request missing");

  AST_ABSENT: assert property (@(posedge clock_i) disable iff (srst_i)
    (!HAS_LIN |-> !lbd_flag_reg) and (!HAS_FLOW_CTRL |-> !cts_flag_reg))
    else $error("absent feature shows a flag");

  AST_RESET: assert property (@(posedge clock_i)
    srst_i |=> !rto_flag_reg && !cts_flag_reg && !lbd_flag_reg && !irq_o)
    else $error("flags not cleared by reset");

  AST_RESET_STAT: assert property (@(posedge clock_i)
    srst_i |=> !status_o.clear_to_send_status)
    else $error("live status not cleared by reset");

  // These read internal terms so a failure points at the flag at fault
  // Further timeout checks
  AST_RTO_HOLD: assert property (@(posedge clock_i) disable iff (srst_i)
    (rto_flag_reg && !clr_rto) |=> rto_flag_reg)
    else $error("timeout flag lost without clear");

  AST_RTO_OFF: assert property (@(posedge clock_i) disable iff (srst_i)
    (!ctrl_i.rx_enable_bit && !rto_flag_reg) |=> !rto_flag_reg)
    else $error("timeout flag set with receiver disabled");

  AST_RTO_QUIET: assert property (@(posedge clock_i) disable iff (srst_i)
    (rto_restart && !rto_flag_reg && !set_rto)
    |=> !rto_flag_reg ##1 !rto_flag_reg)
    else $error("timeout flag set right after line activity");

  AST_RTO_ABSENT: assert property (@(posedge clock_i) disable iff (srst_i)
    (!HAS_RX_TIMEOUT |-> !rto_flag_reg)
    and (!HAS_FLOW_CTRL |-> !status_o.clear_to_send_status))
    else $error("absent feature shows a status bit");

  // Further clear-to-send checks
  AST_CTS_CLR: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(cts_flag_reg) |-> $past(clr_cts))
    else $error("change flag dropped without clear");

  AST_CTS_OFF: assert property (@(posedge clock_i) disable iff (srst_i)
    (!ctrl_i.clear_to_send_detect_enable && !cts_flag_reg) |=> !cts_flag_reg)
    else $error("change flag set with detection disabled");

  AST_CTS_WINS: assert property (@(posedge clock_i) disable iff (srst_i)
    (set_cts && clr_cts)
    |=> cts_flag_reg)
    else $error("clear beat a toggle in the same cycle");

  AST_CTS_IRQ_ON: assert property (@(posedge clock_i) disable iff (srst_i)
    (cts_flag_reg && irq_en_i.clear_to_send_change_irq_enable) |=> irq_o)
    else $error("change request missing");

  AST_IRQ_MASKED: assert property (@(posedge clock_i) disable iff (srst_i)
    (!(rto_flag_reg && irq_en_i.rx_timeout_irq_enable)
     && !(cts_flag_reg && irq_en_i.clear_to_send_change_irq_enable)
     && !(lbd_flag_reg && irq_en_i.lin_break_irq_enable)) |=> !irq_o)
    else $error("request with every flag masked");

  // Further break checks
  AST_LBD_SET_ON: assert property (@(posedge clock_i) disable iff (srst_i)
    (HAS_LIN && ctrl_i.lin_mode_en && lbd_reached && !lbd_fired_reg)
    |=> lbd_flag_reg)
    else $error("break flag not set after low run");

  AST_LBD_HOLD: assert property (@(posedge clock_i) disable iff (srst_i)
    (lbd_flag_reg && !clr_lbd) |=> lbd_flag_reg)
    else $error("break flag lost without clear");

  AST_LBD_OFF: assert property (@(posedge clock_i) disable iff (srst_i)
    (!ctrl_i.lin_mode_en && !lbd_flag_reg) |=> !lbd_flag_reg)
    else $error("break flag set outside break mode");

  AST_LBD_QUIET: assert property (@(posedge clock_i) disable iff (srst_i)
    (rx_i && !lbd_reached && !lbd_flag_reg)
    |=> !lbd_flag_reg ##1 !lbd_flag_reg)
    else $error("break flag set on a high line");

endmodule

// ===== design/urf_pkg.sv
// Purpose: Shared constants and carriers for the receiver status-flag block
// Assumes: One 250 MHz clock, synchronous active-high reset
// Notes:   Counts are in receiver sample ticks (8 or 16 per bit)
package urf_pkg;

  // Widths
  localparam int VAL_W      = 24;
  localparam int DIV_W      = 16;
  localparam int CNT_W      = 30;

  // Clock
  localparam int CLK_PERIOD_NS = 4;

  // Samples per bit for the two oversampling methods
  localparam logic [4:0] SAMPLES_OVS16 = 5'h10;
  localparam logic [4:0] SAMPLES_OVS8  = 5'h08;

  // Extra samples a gap must exceed the programmed value by
  localparam logic [CNT_W-1:0] TIMEOUT_TOL_SAMPLES = 30'h2;

  // Break lengths in bit times
  localparam logic [3:0] LIN_BREAK_BITS_SHORT = 4'hA;
  localparam logic [3:0] LIN_BREAK_BITS_LONG  = 4'hB;

  // Reset values
  localparam logic FLAG_RST   = 1'b0;
  localparam logic STATUS_RST = 1'b0;

  // One write to the flag clear register; bits act only when wr is high
  typedef struct packed {
    logic wr;
    logic rx_timeout_clear_bit;
    logic clear_to_send_change_clear_bit;
    logic lin_break_clear_bit;
  } urf_clear_t;

  // Control bits that steer the flag logic
  typedef struct packed {
    logic rx_enable_bit;
    logic rx_timeout_en;
    logic oversample8;
    logic smartcard_mode;
    logic block_wait_sel;
    logic clear_to_send_detect_enable;
    logic lin_mode_en;
    logic lin_break_long;
  } urf_ctrl_t;

  // Interrupt enable bits
  typedef struct packed {
    logic rx_timeout_irq_enable;
    logic clear_to_send_change_irq_enable;
    logic lin_break_irq_enable;
  } urf_irq_en_t;

  // Status as read by software
  typedef struct packed {
    logic rx_idle_timeout_flag;
    logic clear_to_send_status;
    logic clear_to_send_change_flag;
    logic lin_break_flag;
  } urf_status_t;

  // Which waiting time is being measured
  typedef enum logic {
    WAIT_IDLE,
    WAIT_SMARTCARD
  } urf_wait_mode_t;

endpackage

// ===== design/urf_run_timer.sv
// Purpose: Counts sample ticks while a condition lasts, flags a reached limit
// Assumes: restart_i held whenever the measured condition is broken
// Notes:   Saturates so a long gap never wraps back under the limit
`timescale 1ns/1ns
module urf_run_timer
  import urf_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  // Timing
  input  wire logic         tick_i,
  input  wire logic         restart_i,
  input  wire logic [W-1:0] limit_i,
  output logic              reached_o
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  wire          at_max = &cnt_reg;

  assign cnt_next = restart_i          ? '0 :
                    (tick_i && !at_max) ? cnt_reg + W'(1) : cnt_reg;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cnt_reg   <= '0;
      reached_o <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      reached_o <= !restart_i && (cnt_next >= limit_i);
    end
  end

endmodule

// ===== design/urf_tick_div.sv
// Purpose: Sample tick divider, one-cycle enable per receiver sample
// Assumes: Divisor of zero behaves as one
// Notes:   Output is a registered pulse
`timescale 1ns/1ns
module urf_tick_div
  import urf_pkg::*;
#(
  parameter int W = DIV_W
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  // Divisor and tick
  input  wire logic [W-1:0] div_i,
  output logic              tick_o
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  wire          wrap = (cnt_reg + W'(1)) >= div_i;

  assign cnt_next = wrap ? '0 : cnt_reg + W'(1);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_o  <= wrap;
    end
  end

endmodule

// ===== tb/urf_flags_tb.sv
// Purpose: Self-checking bench for the receiver status-flag block
// Assumes: Tick every clock (divisor 0) except in the divider scenario
// Notes:   A second instance with all features off must read zero
`timescale 1ns/1ns
module urf_flags_tb;
  import urf_pkg::*;
  logic             clock_i;
  logic             srst_i;
  logic             rx;
  logic             cts_n;
  logic             irq;
  logic             irq_bare;
  urf_ctrl_t        ctrl;
  urf_irq_en_t      irq_en;
  urf_clear_t       clr;
  urf_status_t      status;
  urf_status_t      status_bare;
  logic [VAL_W-1:0] to_val;
  logic [VAL_W-1:0] bw_val;
  logic [DIV_W-1:0] sample_div;
  int               failures = 0;
  int               n_checks = 0;
  int               spb;

  urf_line_model i_urf_line_model (.clock_i(clock_i), .rx_o(rx), .cts_n_o(cts_n));

  urf_flags i_urf_flags (.clock_i(clock_i), .srst_i(srst_i), .rx_i(rx),
    .clear_to_send_pin_low_active_i(cts_n), .ctrl_i(ctrl), .irq_en_i(irq_en),
    .sample_div_i(sample_div), .rx_timeout_value_reg_i(to_val),
    .block_wait_value_i(bw_val), .clear_i(clr), .status_o(status), .irq_o(irq));

  urf_flags #(.HAS_RX_TIMEOUT(1'b0), .HAS_FLOW_CTRL(1'b0), .HAS_LIN(1'b0)) i_urf_flags_bare (
    .clock_i(clock_i), .srst_i(srst_i), .rx_i(rx),
    .clear_to_send_pin_low_active_i(cts_n), .ctrl_i(ctrl), .irq_en_i(irq_en),
    .sample_div_i(sample_div), .rx_timeout_value_reg_i(to_val),
    .block_wait_value_i(bw_val), .clear_i(clr), .status_o(status_bare), .irq_o(irq_bare));

  initial begin
    clock_i = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clock_i = ~clock_i;
  end

  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // One-cycle write strobe to the flag clear register
  task automatic clear_flags(input logic [2:0] bits);
    @(negedge clock_i);
    clr = {1'b1, bits};
    @(negedge clock_i);
    clr = 4'h0;
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Whole sequence takes under 2000 clocks
  initial begin
    #(20000 * CLK_PERIOD_NS);
    failures++;
    wrap_up();
  end

  initial begin
    srst_i = 1'b1;
    ctrl   = '0;
    irq_en = '0;
    clr    = '0;
    to_val = 24'h000002;
    bw_val = 24'h000004;
    sample_div = 16'h0000;
    ctrl.rx_timeout_en = 1'b1;
    ctrl.clear_to_send_detect_enable = 1'b1;
    wait_clk(12);
    check(status, 4'h0);
    check({3'h0, irq}, 4'h0);
    srst_i = 1'b0;
    // Idle long past the limit with the receiver off, then switch it on
    wait_clk(50);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h0);
    ctrl.rx_enable_bit = 1'b1;
    wait_clk(2);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h1);
    irq_en.rx_timeout_irq_enable = 1'b1;
    wait_clk(2);
    check({3'h0, irq}, 4'h1);
    irq_en.rx_timeout_irq_enable = 1'b0;
    wait_clk(2);
    check({3'h0, irq}, 4'h0);
    clear_flags(3'b000);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h1);
    clear_flags(3'b100);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h0);
    wait_clk(40);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h0);
    // Timeout enable gates the flag; an elapsed idle shows once enabled
    ctrl.rx_timeout_en = 1'b0;
    i_urf_line_model.low_run(1);
    wait_clk(50);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h0);
    ctrl.rx_timeout_en = 1'b1;
    wait_clk(2);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h1);
    clear_flags(3'b100);
    // Gap of exactly the value, then a long idle, for both sample rates
    for (int ov = 0; ov < 2; ov++) begin
      ctrl.oversample8 = ov[0];
      spb = (ov == 1) ? 8 : 16;
      i_urf_line_model.low_run(1);
      wait_clk(2 * spb - 1);
      i_urf_line_model.low_run(1);
      wait_clk(2);
      check({3'h0, status.rx_idle_timeout_flag}, 4'h0);
      wait_clk(2 * spb + 12);
      check({3'h0, status.rx_idle_timeout_flag}, 4'h1);
      clear_flags(3'b100);
    end
    // Tick every second clock, one-bit value at 8 samples: ten ticks needed
    sample_div = 16'h0002;
    to_val = 24'h000001;
    i_urf_line_model.low_run(1);
    wait_clk(14);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h0);
    wait_clk(16);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h1);
    clear_flags(3'b100);
    sample_div = 16'h0000;
    to_val = 24'h000002;
    // Smartcard: block wait of 3 bits replaces the 2-bit idle value
    bw_val = 24'h000003;
    ctrl.oversample8 = 1'b0;
    ctrl.smartcard_mode = 1'b1;
    ctrl.block_wait_sel = 1'b1;
    i_urf_line_model.low_run(1);
    wait_clk(45);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h0);
    wait_clk(35);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h1);
    clear_flags(3'b100);
    // Character wait counts from the start bit, not from the rising edge
    ctrl.block_wait_sel = 1'b0;
    i_urf_line_model.low_run(8);
    wait_clk(24);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h0);
    wait_clk(9);
    check({3'h0, status.rx_idle_timeout_flag}, 4'h1);
    clear_flags(3'b100);
    ctrl.smartcard_mode = 1'b0;
    // Clear-to-send status and change flag
    irq_en.clear_to_send_change_irq_enable = 1'b1;
    i_urf_line_model.set_cts(1'b0);
    wait_clk(2);
    check({2'h0, status.clear_to_send_status, status.clear_to_send_change_flag}, 4'h3);
    check({3'h0, irq}, 4'h1);
    check({status_bare[3:1], irq_bare}, 4'h0);
    clear_flags(3'b000);
    check({3'h0, status.clear_to_send_change_flag}, 4'h1);
    clear_flags(3'b010);
    check({3'h0, status.clear_to_send_change_flag}, 4'h0);
    wait_clk(2);
    check({3'h0, irq}, 4'h0);
    ctrl.clear_to_send_detect_enable = 1'b0;
    i_urf_line_model.set_cts(1'b1);
    wait_clk(2);
    check({2'h0, status.clear_to_send_status, status.clear_to_send_change_flag}, 4'h0);
    ctrl.clear_to_send_detect_enable = 1'b1;
    i_urf_line_model.set_cts(1'b0);
    wait_clk(2);
    check({3'h0, status.clear_to_send_change_flag}, 4'h1);
    clear_flags(3'b010);
    i_urf_line_model.set_cts(1'b1);
    wait_clk(2);
    check({3'h0, status.clear_to_send_change_flag}, 4'h1);
    clear_flags(3'b010);
    // Break of 168 samples sits between the 10-bit and 11-bit lengths
    ctrl.lin_mode_en = 1'b1;
    irq_en = '0;
    irq_en.lin_break_irq_enable = 1'b1;
    for (int lg = 0; lg < 2; lg++) begin
      ctrl.lin_break_long = lg[0];
      i_urf_line_model.low_run(168);
      wait_clk(2);
      check({3'h0, status.lin_break_flag}, {3'h0, ~lg[0]});
      clear_flags(3'b001);
      i_urf_line_model.low_run(184);
      wait_clk(2);
      check({3'h0, status.lin_break_flag}, 4'h1);
      check({3'h0, irq}, 4'h1);
      clear_flags(3'b001);
      check({3'h0, status.lin_break_flag}, 4'h0);
      wait_clk(2);
      check({3'h0, irq}, 4'h0);
    end
    check(status_bare, 4'h0);
    wrap_up();
  end
endmodule

// ===== tb/urf_line_model.sv
// Purpose: Remote serial device driving the receive and clear-to-send lines
// Assumes: Lines change on the falling edge of clock_i
// Notes:   Both lines idle high, as released lines with pull-ups
`timescale 1ns/1ns
module urf_line_model (
  // Clock
  input  wire logic clock_i,
  // Lines
  output logic      rx_o,
  output logic      cts_n_o
);
  initial begin
    rx_o    = 1'b1;
    cts_n_o = 1'b1;
  end

  // Low run of n clocks; a long one is a break, a short one marks activity
  task automatic low_run(input int n);
    @(negedge clock_i);
    rx_o = 1'b0;
    repeat (n) @(negedge clock_i);
    rx_o = 1'b1;
  endtask

  task automatic set_cts(input logic v);
    @(negedge clock_i);
    cts_n_o = v;
  endtask
endmodule
